// file: rtcsm_cfg.svh
// constants of the seconds/minutes counter: offsets, fields, timing
// assumes nothing; included by bare name wherever a value is needed
`ifndef RTCSM_CFG_SVH
`define RTCSM_CFG_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RTCSM_IDX_SEC      24'hFFFFA8
`define RTCSM_IDX_MIN      24'hFFFFA9
`define RTCSM_IDX_CTRL     24'hFFFFB0
`define RTCSM_IDX_STAT     24'hFFFFB1
`define RTCSM_IDX_MASK     24'hFFFFB2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RTCSM_BUSY_BIT     7
`define RTCSM_CTRL_START   0
`define RTCSM_CTRL_MODE    1
`define RTCSM_CTRL_CSTAT   2
`define RTCSM_EV_SEC       0
`define RTCSM_EV_MIN       1
`define RTCSM_EV_CMP       2
`define RTCSM_EV_W         3

// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define RTCSM_RST_BYTE     8'h00
`define RTCSM_RST_EV       3'h0
`define RTCSM_UNITS_MAX    4'h9
`define RTCSM_TENS_MAX     3'h5
`define RTCSM_WRAP_VAL     7'h59
`define RTCSM_RESP_OKAY    2'h0
`define RTCSM_RESP_SLVERR  2'h2

// ----------------------------------------------------------------
// timing: one second at a 4 ns clock
// ----------------------------------------------------------------
`define RTCSM_SECOND_NS    1000000000
`define RTCSM_CLK_NS       4

`endif

// file: rtcsm_pkg.sv
// types shared by the seconds/minutes counter files
// assumes rtcsm_cfg.svh holds the numeric constants
package rtcsm_pkg;
    // counting mode of the block
    typedef enum logic [0:0] {
        RTCSM_MODE_RTC = 1'b0,
        RTCSM_MODE_OC  = 1'b1
    } rtcsm_mode_e;

    // register selected by a bus address
    typedef enum logic [2:0] {
        RTCSM_SEL_SEC  = 3'b000,
        RTCSM_SEL_MIN  = 3'b001,
        RTCSM_SEL_CTRL = 3'b010,
        RTCSM_SEL_STAT = 3'b011,
        RTCSM_SEL_MASK = 3'b100,
        RTCSM_SEL_NONE = 3'b101
    } rtcsm_sel_e;

    // one counter byte
    typedef logic [7:0] rtcsm_byte_t;
endpackage

// file: rtcsm_cnt_if.sv
// carrier between the top module and one two-digit counter
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface rtcsm_cnt_if;
    logic                 step;    // advance by one
    logic                 clr;     // clear to zero, beats step
    logic                 bin;     // plain binary counting
    logic                 wr_en;   // software load, beats all
    rtcsm_pkg::rtcsm_byte_t wr_data; // value to load
    rtcsm_pkg::rtcsm_byte_t val;     // present count
    logic                 wrap;    // count stands at 59

    modport ctl (output step, clr, bin, wr_en, wr_data,
                 input  val, wrap);
    modport cnt (input  step, clr, bin, wr_en, wr_data,
                 output val, wrap);
endinterface

// file: rtcsm_digit_cnt.sv
// two-digit BCD counter 00..59 that can also count plain binary
// assumes a synchronous active-high reset on sys_clk
`timescale 1ns/1ps
`include "rtcsm_cfg.svh"
module rtcsm_digit_cnt (
    // clock and reset
    input wire logic     sys_clk,
    input wire logic     reset,
    // control and count
    rtcsm_cnt_if.cnt     cif
);
    rtcsm_pkg::rtcsm_byte_t val_r; // held count

    // ------------------------------------------------------------
    // counting
    // ------------------------------------------------------------
    // write beats clear, clear beats step
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            val_r <= `RTCSM_RST_BYTE;
        end else if (cif.wr_en) begin
            val_r <= cif.wr_data;
        end else if (cif.clr) begin
            val_r <= `RTCSM_RST_BYTE;
        end else if (cif.step && cif.bin) begin
            val_r <= val_r + 8'h01;
        end else if (cif.step) begin
            // units 0..9, carry into tens
            if (val_r[3:0] >= `RTCSM_UNITS_MAX) begin
                val_r[3:0] <= 4'h0;
                // tens 0..5, so a written bad digit also wraps
                if (val_r[6:4] >= `RTCSM_TENS_MAX) begin
                    val_r[6:4] <= 3'h0;
                end else begin
                    val_r[6:4] <= val_r[6:4] + 3'h1;
                end
            end else begin
                val_r[3:0] <= val_r[3:0] + 4'h1;
            end
            val_r[7] <= 1'b0;
        end
    end

    assign cif.val  = val_r;
    // carry out of the pair at 59
    assign cif.wrap = (val_r[6:0] == `RTCSM_WRAP_VAL);
endmodule

// file: rtcsm_top.sv
// seconds/minutes counter with output-compare mode, AXI4-Lite slave
// assumes one clock sys_clk and a synchronous active-high reset;
// the bus master keeps the AXI4-Lite handshake rules
//
// Operation
// - busy bit 7 high while values update, in clock mode only
// - seconds units 0..9, carry to tens
// - seconds tens count 0..5 only
// - seconds BCD 00 to 59, then wraps
// - minutes units 0..9, carry to tens
// - minutes tens count 0..5 only
// - compare mode: seconds is binary counter
// - stopped counter holds its value
// - compare match clears counter to zero
// - minutes step only on seconds carry
// - minutes BCD 00 to 59, then wraps
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rtcsm_cfg.svh"
module rtcsm_top #(
    parameter int unsigned ADDR_W      = 26,
    parameter int unsigned TICK_CYCLES =
        `RTCSM_SECOND_NS / `RTCSM_CLK_NS
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset,
    // write address channel
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // write data channel
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // write response channel
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // read address channel
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // read data channel
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // interrupt
    output logic                   irq
);
    localparam int unsigned IDX_W = ADDR_W - 2;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    // bus side
    logic                  awready_r;  // write address ready
    logic                  wready_r;   // write data ready
    logic                  bvalid_r;   // write answer pending
    logic [1:0]            bresp_r;    // write answer code
    logic                  arready_r;  // read address ready
    logic                  rvalid_r;   // read answer pending
    logic [1:0]            rresp_r;    // read answer code
    logic [31:0]           rdata_r;    // read answer data
    logic                  aw_full_r;  // address captured
    logic                  w_full_r;   // data captured
    logic [IDX_W-1:0]      aw_idx_r;   // captured word index
    logic [7:0]            wdata_r;    // captured low byte
    logic                  wlane_r;    // byte lane 0 enabled
    logic                  do_wr;      // write takes effect now
    rtcsm_pkg::rtcsm_sel_e wr_sel;     // register written
    rtcsm_pkg::rtcsm_sel_e rd_sel;     // register read
    // control and state
    logic                  start_r;    // count start bit
    rtcsm_pkg::rtcsm_mode_e mode_r;    // counting mode
    logic                  cstat_r;    // counting status flag
    logic [31:0]           pre_r;      // one-second prescaler
    logic                  tick;       // prescaler ends a second
    logic                  busy_r;     // update in progress
    logic                  upd;        // counters change now
    logic                  oc_mode;    // output-compare selected
    logic                  match;      // compare match this step
    // events
    logic [`RTCSM_EV_W-1:0] stat_r;    // sticky event flags
    logic [`RTCSM_EV_W-1:0] mask_r;    // event enables
    logic [`RTCSM_EV_W-1:0] ev;        // events this cycle
    logic [`RTCSM_EV_W-1:0] w1c;       // flags cleared now
    logic                  irq_r;      // interrupt level
    // counter pair: 0 seconds/counter, 1 minutes/compare
    rtcsm_pkg::rtcsm_byte_t val_w [2];
    logic                  wrap_w [2];
    rtcsm_cnt_if           cif [2] ();

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // maps a word index onto a register; others are unmapped
    function automatic rtcsm_pkg::rtcsm_sel_e dec(
        input logic [IDX_W-1:0] idx);
        case (idx)
            IDX_W'(`RTCSM_IDX_SEC):  return rtcsm_pkg::RTCSM_SEL_SEC;
            IDX_W'(`RTCSM_IDX_MIN):  return rtcsm_pkg::RTCSM_SEL_MIN;
            IDX_W'(`RTCSM_IDX_CTRL): return rtcsm_pkg::RTCSM_SEL_CTRL;
            IDX_W'(`RTCSM_IDX_STAT): return rtcsm_pkg::RTCSM_SEL_STAT;
            IDX_W'(`RTCSM_IDX_MASK): return rtcsm_pkg::RTCSM_SEL_MASK;
            default:                 return rtcsm_pkg::RTCSM_SEL_NONE;
        endcase
    endfunction

    assign wr_sel = dec(aw_idx_r);
    assign rd_sel = dec(s_axi_araddr[ADDR_W-1:2]);
    // both halves held and no answer outstanding
    assign do_wr  = aw_full_r && w_full_r && !bvalid_r;

    // ------------------------------------------------------------
    // write address and data capture
    // ------------------------------------------------------------
    // either channel may come first; each drops ready once taken
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            awready_r <= 1'b1;
            aw_full_r <= 1'b0;
            aw_idx_r  <= '0;
        end else if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_full_r <= 1'b1;
            aw_idx_r  <= s_axi_awaddr[ADDR_W-1:2];
        end else if (bvalid_r && s_axi_bready) begin
            awready_r <= 1'b1;
            aw_full_r <= 1'b0;
        end
    end

    // data half; only byte lane 0 holds register bits
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wready_r <= 1'b1;
            w_full_r <= 1'b0;
            wdata_r  <= `RTCSM_RST_BYTE;
            wlane_r  <= 1'b0;
        end else if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_full_r <= 1'b1;
            wdata_r  <= s_axi_wdata[7:0];
            wlane_r  <= s_axi_wstrb[0];
        end else if (bvalid_r && s_axi_bready) begin
            wready_r <= 1'b1;
            w_full_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // write response
    // ------------------------------------------------------------
    // unmapped index answers SLVERR, anything else OKAY
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `RTCSM_RESP_OKAY;
        end else if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (wr_sel == rtcsm_pkg::RTCSM_SEL_NONE) ?
                        `RTCSM_RESP_SLVERR : `RTCSM_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    // data sampled at the address handshake, held until taken
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= `RTCSM_RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rresp_r   <= `RTCSM_RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
            unique case (rd_sel)
                rtcsm_pkg::RTCSM_SEL_SEC: begin
                    // busy shows in bit 7 in clock mode
                    rdata_r[7:0] <= oc_mode ? val_w[0] :
                                    {busy_r, val_w[0][6:0]};
                end
                rtcsm_pkg::RTCSM_SEL_MIN: begin
                    rdata_r[7:0] <= oc_mode ? val_w[1] :
                                    {busy_r, val_w[1][6:0]};
                end
                rtcsm_pkg::RTCSM_SEL_CTRL: begin
                    rdata_r[`RTCSM_CTRL_START] <= start_r;
                    rdata_r[`RTCSM_CTRL_MODE]  <= oc_mode;
                    rdata_r[`RTCSM_CTRL_CSTAT] <= cstat_r;
                end
                rtcsm_pkg::RTCSM_SEL_STAT: begin
                    rdata_r[`RTCSM_EV_W-1:0] <= stat_r;
                end
                rtcsm_pkg::RTCSM_SEL_MASK: begin
                    rdata_r[`RTCSM_EV_W-1:0] <= mask_r;
                end
                default: begin
                    rresp_r <= `RTCSM_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // start and mode are written by software
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            start_r <= 1'b0;
            mode_r  <= rtcsm_pkg::RTCSM_MODE_RTC;
        end else if (do_wr && wlane_r &&
                     wr_sel == rtcsm_pkg::RTCSM_SEL_CTRL) begin
            start_r <= wdata_r[`RTCSM_CTRL_START];
            mode_r  <= rtcsm_pkg::rtcsm_mode_e'(
                       wdata_r[`RTCSM_CTRL_MODE]);
        end
    end

    assign oc_mode = (mode_r == rtcsm_pkg::RTCSM_MODE_OC);

    // status follows start one cycle later, so software can see
    // when counting has really stopped before it loads compare
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cstat_r <= 1'b0;
        end else begin
            cstat_r <= start_r;
        end
    end

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    // prescaler runs only while counting, else holds at zero
    always_ff @(posedge sys_clk) begin
        if (reset || !cstat_r || tick) begin
            pre_r <= 32'h0000_0000;
        end else begin
            pre_r <= pre_r + 32'h0000_0001;
        end
    end

    assign tick = cstat_r && (pre_r == 32'(TICK_CYCLES - 1));

    // busy for the one cycle before values change; the change
    // lands at the edge that ends busy
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= tick;
        end
    end

    assign upd = busy_r;

    // ------------------------------------------------------------
    // counter pair
    // ------------------------------------------------------------
    // counter equal to compare at a step is a match
    assign match = upd && oc_mode && (val_w[0] == val_w[1]);

    // seconds: BCD step in clock mode, binary in compare mode
    assign cif[0].step  = upd;
    assign cif[0].clr   = match;
    assign cif[0].bin   = oc_mode;
    // minutes: only the seconds carry moves it
    assign cif[1].step  = upd && !oc_mode && wrap_w[0];
    assign cif[1].clr   = 1'b0;
    assign cif[1].bin   = 1'b0;
    // software loads win over a step at the same edge
    assign cif[0].wr_en = do_wr && wlane_r &&
                          wr_sel == rtcsm_pkg::RTCSM_SEL_SEC;
    assign cif[1].wr_en = do_wr && wlane_r &&
                          wr_sel == rtcsm_pkg::RTCSM_SEL_MIN;
    // bit 7 is writable only as the compare value's top bit
    assign cif[0].wr_data = {1'b0, wdata_r[6:0]};
    assign cif[1].wr_data = oc_mode ? wdata_r : {1'b0, wdata_r[6:0]};

    // one counter per register
    for (genvar i = 0; i < 2; i++) begin : g_cnt
        assign val_w[i]       = cif[i].val;
        assign wrap_w[i]      = cif[i].wrap;
        // seconds minutes
        rtcsm_digit_cnt rtcsm_digit_cnt_i (
            .sys_clk (sys_clk),
            .reset   (reset),
            .cif     (cif[i])
        );
    end

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    assign ev[`RTCSM_EV_SEC] = upd && !oc_mode;
    assign ev[`RTCSM_EV_MIN] = upd && !oc_mode && wrap_w[0];
    assign ev[`RTCSM_EV_CMP] = match;
    assign w1c = (do_wr && wlane_r &&
                  wr_sel == rtcsm_pkg::RTCSM_SEL_STAT) ?
                 wdata_r[`RTCSM_EV_W-1:0] : `RTCSM_RST_EV;

    // sticky flags; a new event beats a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stat_r <= `RTCSM_RST_EV;
        end else begin
            stat_r <= (stat_r & ~w1c) | ev;
        end
    end

    // event enables
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mask_r <= `RTCSM_RST_EV;
        end else if (do_wr && wlane_r &&
                     wr_sel == rtcsm_pkg::RTCSM_SEL_MASK) begin
            mask_r <= wdata_r[`RTCSM_EV_W-1:0];
        end
    end

    // level output, one cycle behind the flags
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_r & mask_r);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;
    assign irq           = irq_r;
endmodule

// file: rtcsm_top_sva.sv
// checker for the seconds/minutes counter bus and interrupt ports
// assumes it is bound to rtcsm_top and sees only its ports
`timescale 1ns/1ps
module rtcsm_top_sva (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        reset,
    // write side
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // read side
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // interrupt
    input wire logic        irq
);
    // ------------------------------------------------------------
    // properties, all on the single clock
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    // a waiting answer must not move under the master, and a write answer goes once taken
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    chk_b_clears: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("bvalid stuck");
    // answer latency as handed over
    chk_r_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    chk_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer off");
    // one transfer at a time keeps the register file simple
    chk_wr_blocked: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
    chk_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read overlap");
    // registers are one byte wide
    chk_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper");
    chk_unmapped_zero: assert property (s_axi_rvalid &&
        s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0) else $error("unmap");
    chk_irq_quiet: assert property ($fell(reset) |-> !irq)
        else $error("irq after reset");

    // main scenarios
    cov_write: cover property (s_axi_bvalid && s_axi_bready);
    cov_read: cover property (s_axi_rvalid && s_axi_rready);
    cov_irq: cover property ($rose(irq));
endmodule

// file: rtc_seconds_minutes_counter_bench.sv
// self-checking bench for rtcsm_top, driven over AXI4-Lite
// assumes rtcsm_top_sva.sv and the design files are compiled first
`timescale 1ns/1ps
`include "rtcsm_cfg.svh"
module rtc_seconds_minutes_counter_bench;
    // ------------------------------------------------------------
    // stimulus and wiring; short tick keeps the run brief
    // ------------------------------------------------------------
    localparam int TICK = 40;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [25:0] awaddr = 26'h0;
    logic [25:0] araddr = 26'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          n_mismatch = 0;
    int          compares = 0;

    always #2 sys_clk = ~sys_clk;

    rtcsm_top #(.TICK_CYCLES(TICK)) rtcsm_top_i (.sys_clk(sys_clk),
        .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

    task automatic final_report;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic miss(input string m);
        n_mismatch++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    task automatic chk(input logic [31:0] got, exp, input string m);
        compares++;
        if (got !== exp) miss(m);
    endtask

    // bus write; each channel released at its own handshake
    task automatic wr(input logic [23:0] ix, input logic [7:0] d,
                      input logic [1:0] er = 2'h0);
        int n;
        @(posedge sys_clk);
        awaddr <= {ix, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50 && !bvalid; n++) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        if (n == 50) begin
            miss("write hang");
            final_report;
        end
        bready <= 1'b0;
        chk(bresp, er, "write response");
    endtask

    task automatic rd(input logic [23:0] ix, output logic [31:0] d,
                      input logic [1:0] er = 2'h0);
        int n;
        @(posedge sys_clk);
        araddr <= {ix, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50 && !rvalid; n++) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        if (n == 50) begin
            miss("read hang");
            final_report;
        end
        d = rdata;
        rready <= 1'b0;
        chk(rresp, er, "read response");
    endtask

    // poll seconds until a settled value differs from prev
    task automatic step(input logic [7:0] prev, input logic rtc,
                        output logic [7:0] v);
        logic [31:0] d;
        int          n;
        for (n = 0; n < 400; n++) begin
            rd(`RTCSM_IDX_SEC, d);
            if ((!rtc || !d[7]) && d[7:0] != prev) break;
        end
        if (n == 400) begin
            miss("no step");
            final_report;
        end
        v = d[7:0];
    endtask

    task automatic t_reset;
        logic [23:0] ix[5] = '{`RTCSM_IDX_SEC, `RTCSM_IDX_MIN,
            `RTCSM_IDX_CTRL, `RTCSM_IDX_STAT, `RTCSM_IDX_MASK};
        logic [31:0] d;
        foreach (ix[i]) begin
            rd(ix[i], d);
            chk(d, 32'h0, "reset value");
        end
        rd(24'h000010, d, 2'h2);
        chk(d, 32'h0, "unmapped read");
        wr(24'h000010, 8'hFF, 2'h2);
        wr(`RTCSM_IDX_CTRL, 8'h04);
        rd(`RTCSM_IDX_CTRL, d);
        chk(d, 32'h0, "status flag writable");
        $display("test reset done");
    endtask

    // clock mode carries: sec, min before and after one step
    task automatic t_clock;
        logic [7:0]  tb[4][4] = '{'{8'h09, 8'h00, 8'h10, 8'h00},
            '{8'h59, 8'h07, 8'h00, 8'h08}, '{8'h59, 8'h09, 8'h00, 8'h10},
            '{8'h59, 8'h59, 8'h00, 8'h00}};
        logic [7:0]  v;
        logic [31:0] d;
        foreach (tb[i]) begin
            wr(`RTCSM_IDX_CTRL, 8'h00);
            wr(`RTCSM_IDX_SEC, tb[i][0]);
            wr(`RTCSM_IDX_MIN, tb[i][1]);
            wr(`RTCSM_IDX_CTRL, 8'h01);
            step(tb[i][0], 1'b1, v);
            chk(v, tb[i][2], "seconds step");
            rd(`RTCSM_IDX_MIN, d);
            chk(d[6:0], tb[i][3], "minutes");
        end
        rd(`RTCSM_IDX_CTRL, d);
        chk(d, 32'h05, "running status");
        $display("test clock done");
    endtask

    task automatic irq_is(input logic e);
        repeat (3) @(posedge sys_clk);
        chk(irq, e, "irq level");
    endtask

    task automatic t_irq;
        logic [31:0] d;
        wr(`RTCSM_IDX_CTRL, 8'h00);
        rd(`RTCSM_IDX_STAT, d);
        chk(d, 32'h03, "second and minute events");
        wr(`RTCSM_IDX_MASK, 8'h01);
        irq_is(1'b1);
        wr(`RTCSM_IDX_MASK, 8'h00);
        irq_is(1'b0);
        wr(`RTCSM_IDX_MASK, 8'h03);
        wr(`RTCSM_IDX_STAT, 8'h03);
        irq_is(1'b0);
        rd(`RTCSM_IDX_STAT, d);
        chk(d, 32'h0, "status cleared");
        $display("test irq done");
    endtask

    // compare mode: start value, compare value, then expected steps
    task automatic t_compare;
        logic [7:0]  tb[2][6] = '{'{8'h00, 8'h03, 8'h01, 8'h02, 8'h03,
            8'h00}, '{8'h7E, 8'hFF, 8'h7F, 8'h80, 8'h81, 8'h82}};
        logic [7:0]  v;
        logic [31:0] d, a;
        foreach (tb[i]) begin
            wr(`RTCSM_IDX_CTRL, 8'h02);
            wr(`RTCSM_IDX_SEC, tb[i][0]);
            wr(`RTCSM_IDX_MIN, tb[i][1]);
            wr(`RTCSM_IDX_CTRL, 8'h03);
            v = tb[i][0];
            for (int k = 2; k < 6; k++) begin
                step(v, 1'b0, v);
                chk(v, tb[i][k], "counter step");
            end
        end
        rd(`RTCSM_IDX_STAT, d);
        chk(d & 32'h04, 32'h04, "match event");
        wr(`RTCSM_IDX_CTRL, 8'h02);
        rd(`RTCSM_IDX_SEC, a);
        repeat (100) @(posedge sys_clk);
        rd(`RTCSM_IDX_SEC, d);
        chk(d, a, "stopped counter");
        $display("test compare done");
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset;
        t_clock;
        t_irq;
        t_compare;
        final_report;
    end
endmodule

bind rtcsm_top rtcsm_top_sva rtcsm_top_sva_i (.*);
